/* logic/prx_dev.sv */
// Endpoint end: packet FIFOs, non-posted reordering and stream delivery
//
// Overview of operation
// [RULE1] Valid with first full QWORD of packet
// [RULE2] Next QWORD each ready cycle, no gaps
// [RULE3] Last beat marked; strobe FF or 0F
// [RULE4] Drop valid when no further packet
// [RULE5] User ignores stream fields without valid
// [RULE6] Idle and not ready: hold first beat
// [RULE7] Stall mid-packet while ready low, unbounded
// [RULE8] New packet may follow last beat directly
// [RULE9] User takes back-to-back or lowers ready
// [RULE10] Posted and completions pass blocked non-posted
// [RULE11] One non-posted mechanism, chosen at build
// [RULE12] Throttle: at most two after ok drops
// [RULE13] User drops ok two clocks early
// [RULE14] While ok low, others still delivered
// [RULE15] Ok back high: waiting non-posted first
// [RULE16] User avoids long ok low periods
// [RULE17] User buffers at least three non-posted
// [RULE18] User counts free non-posted buffers
// [RULE19] User drives ok from free count
// [RULE20] User pulses request once per packet
// [RULE21] Remember up to twelve request pulses
// [RULE22] Everything on rising edge, one clock
`timescale 1ns/100ps
`default_nettype none

module prx_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = cnt_q != FULL;
    assign out_valid = cnt_q != '0;
    assign out_data = mem[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : prx_fifo

module prx_dev #(
    parameter bit NP_REQ_MODE = 1'b0
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Packets arriving from the transaction layer
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [prx_pkg::QW_W-1:0] IN_DATA,
    input wire logic IN_LAST,
    input wire logic [prx_pkg::STRB_W-1:0] IN_STRB,
    // Stream toward user logic
    prx_link_if.dev LINK
);
    localparam int BW = $bits(prx_pkg::prx_beat_t);

    // Ingress side
    logic in_sof_q;
    logic in_np_q;
    logic [prx_pkg::PKT_CNT_W-1:0] pc_wr_q;
    logic [prx_pkg::PKT_CNT_W-1:0] pc_rd_q;
    logic [prx_pkg::PKT_CNT_W-1:0] np_pkts_q;
    logic [prx_pkg::PKT_CNT_W-1:0] pc_pkts_q;
    logic [prx_pkg::CREDIT_W-1:0] credit_q;
    prx_pkg::prx_beat_t in_beat;
    prx_pkg::prx_beat_t np_head;
    prx_pkg::prx_beat_t pc_head;
    prx_pkg::prx_beat_t out_beat;
    logic np_in_ready;
    logic pc_in_ready;
    wire np_pop;
    wire pc_pop;

    // Delivery side
    logic ov_q;
    logic [prx_pkg::QW_W-1:0] od_q;
    logic olast_q;
    logic [prx_pkg::STRB_W-1:0] ostrb_q;
    logic mid_q;
    prx_pkg::prx_src_t src_q;

    wire in_cls = in_sof_q ? prx_pkg::prx_is_np(IN_DATA[31:0]) : in_np_q;
    wire np_push = IN_VALID && in_cls && np_in_ready;
    wire pc_push = IN_VALID && !in_cls && pc_in_ready;
    assign IN_READY = in_cls ? np_in_ready : pc_in_ready;

    assign in_beat.tag = pc_wr_q;
    assign in_beat.half = IN_STRB == prx_pkg::STRB_LOW;
    assign in_beat.last = IN_LAST;
    assign in_beat.data = IN_DATA;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            in_sof_q <= 1'b1;
            in_np_q <= 1'b0;
        end else if (IN_VALID && IN_READY) begin
            in_sof_q <= IN_LAST;
            in_np_q <= in_cls;
        end
    end

    // Two queues so completions and posted writes can overtake held requests
    prx_fifo #(.W(BW), .DEPTH(prx_pkg::FIFO_DEPTH)) u_np_fifo ( // RULE10
        .clk(CLK_SYS),
        .srst(SRST),
        .in_valid(IN_VALID && in_cls),
        .in_ready(np_in_ready),
        .in_data(in_beat),
        .out_valid(),
        .out_ready(np_pop),
        .out_data(np_head)
    );

    prx_fifo #(.W(BW), .DEPTH(prx_pkg::FIFO_DEPTH)) u_pc_fifo (
        .clk(CLK_SYS),
        .srst(SRST),
        .in_valid(IN_VALID && !in_cls),
        .in_ready(pc_in_ready),
        .in_data(in_beat),
        .out_valid(),
        .out_ready(pc_pop),
        .out_data(pc_head)
    );

    // Mechanism chosen by parameter; the other input is never read
    wire np_allow = NP_REQ_MODE ? (credit_q != '0) : LINK.nonposted_accept_ok; // RULE11 RULE12
    // Older posted packets all started once the read count has reached the tag;
    // holds while fewer than 64 posted packets overtake one held request
    wire [prx_pkg::PKT_CNT_W-1:0] np_lag = pc_rd_q - np_head.tag;
    wire [prx_pkg::PKT_CNT_W-1:0] np_ahead = pc_wr_q - np_head.tag;
    wire np_older_done = np_lag <= np_ahead;
    wire np_eligible = (np_pkts_q != '0) && np_older_done && np_allow; // RULE15
    wire adv = !ov_q || LINK.tready; // RULE6 RULE7
    wire cont = adv && mid_q;
    wire take_np = adv && !mid_q && np_eligible;
    wire take_pc = adv && !mid_q && !np_eligible && (pc_pkts_q != '0); // RULE14
    assign np_pop = take_np || (cont && src_q == prx_pkg::SRC_NP);
    assign pc_pop = take_pc || (cont && src_q == prx_pkg::SRC_PC);
    wire popped = np_pop || pc_pop;
    assign out_beat = np_pop ? np_head : pc_head;
    wire [prx_pkg::STRB_W-1:0] beat_strb =
        (out_beat.last && out_beat.half) ? prx_pkg::STRB_LOW : prx_pkg::STRB_FULL;

    wire np_wr_last = np_push && IN_LAST;
    wire pc_wr_last = pc_push && IN_LAST;
    wire np_rd_last = np_pop && np_head.last;
    wire pc_rd_last = pc_pop && pc_head.last;

    // Only whole packets are started, so a packet never has an idle beat
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            np_pkts_q <= prx_pkg::PKT_CNT_RST;
            pc_pkts_q <= prx_pkg::PKT_CNT_RST;
            pc_wr_q <= prx_pkg::PKT_CNT_RST;
            pc_rd_q <= prx_pkg::PKT_CNT_RST;
        end else begin
            np_pkts_q <= np_pkts_q + prx_pkg::PKT_CNT_W'(np_wr_last)
                         - prx_pkg::PKT_CNT_W'(np_rd_last); // RULE2
            pc_pkts_q <= pc_pkts_q + prx_pkg::PKT_CNT_W'(pc_wr_last)
                         - prx_pkg::PKT_CNT_W'(pc_rd_last);
            pc_wr_q <= pc_wr_q + prx_pkg::PKT_CNT_W'(pc_push && in_sof_q);
            pc_rd_q <= pc_rd_q + prx_pkg::PKT_CNT_W'(take_pc);
        end
    end

    // Credits saturate; a pulse beyond the limit is lost
    wire credit_inc = NP_REQ_MODE && LINK.nonposted_credit_request
                      && (credit_q != prx_pkg::NP_CREDIT_MAX || take_np);
    wire credit_dec = NP_REQ_MODE && take_np;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            credit_q <= prx_pkg::CREDIT_RST;
        end else begin
            credit_q <= credit_q + prx_pkg::CREDIT_W'(credit_inc)
                        - prx_pkg::CREDIT_W'(credit_dec); // RULE21
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ov_q <= 1'b0;
            od_q <= '0;
            olast_q <= 1'b0;
            ostrb_q <= prx_pkg::STRB_FULL;
            mid_q <= 1'b0;
            src_q <= prx_pkg::SRC_PC;
        end else if (popped) begin
            ov_q <= 1'b1; // RULE1 RULE8
            od_q <= out_beat.data;
            olast_q <= out_beat.last;
            ostrb_q <= beat_strb; // RULE3
            mid_q <= !out_beat.last;
            if (take_np) begin
                src_q <= prx_pkg::SRC_NP;
            end else if (take_pc) begin
                src_q <= prx_pkg::SRC_PC;
            end
        end else if (adv) begin
            ov_q <= 1'b0; // RULE4
        end
    end

    assign LINK.tvalid = ov_q;
    assign LINK.tdata = od_q;
    assign LINK.tlast = olast_q;
    assign LINK.tstrb = ostrb_q;
endmodule : prx_dev
`default_nettype wire

/* logic/prx_user.sv */
// User end: stream capture, non-posted buffer accounting and flow signals
`timescale 1ns/100ps
`default_nettype none
module prx_user #(
    parameter bit NP_REQ_MODE = 1'b0,
    parameter logic [4:0] NP_SLOTS = prx_pkg::NP_SLOTS_DEF
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Stream from the endpoint
    prx_link_if.usr LINK,
    // Captured beats toward the application
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [prx_pkg::QW_W-1:0] OUT_DATA,
    output logic OUT_LAST,
    output logic [prx_pkg::STRB_W-1:0] OUT_STRB,
    output logic OUT_NP,
    // Application finished one non-posted packet
    input wire logic NP_DRAIN
);
    logic sof_q;
    logic np_pkt_q;
    logic [4:0] free_q;
    logic [3:0] issued_q;
    logic ok_q;
    logic req_q;

    // Stalls the endpoint while a captured beat waits and the application holds off
    assign LINK.tready = !OUT_VALID || OUT_READY; // RULE9
    wire acc = LINK.tvalid && LINK.tready; // RULE5
    wire beat_np = sof_q ? prx_pkg::prx_is_np(LINK.tdata[31:0]) : np_pkt_q;
    wire np_sof = acc && sof_q && beat_np;
    wire drain = NP_DRAIN && free_q != NP_SLOTS;
    wire req_d = NP_REQ_MODE && ({1'b0, issued_q} < free_q)
                 && issued_q != prx_pkg::NP_CREDIT_MAX; // RULE20

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            OUT_VALID <= 1'b0;
            OUT_DATA <= '0;
            OUT_LAST <= 1'b0;
            OUT_STRB <= prx_pkg::STRB_FULL;
            OUT_NP <= 1'b0;
            sof_q <= 1'b1;
            np_pkt_q <= 1'b0;
        end else if (acc) begin
            OUT_VALID <= 1'b1;
            OUT_DATA <= LINK.tdata;
            OUT_LAST <= LINK.tlast;
            OUT_STRB <= LINK.tstrb;
            OUT_NP <= beat_np;
            sof_q <= LINK.tlast;
            np_pkt_q <= beat_np;
        end else if (OUT_READY) begin
            OUT_VALID <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            free_q <= NP_SLOTS;
            issued_q <= prx_pkg::CREDIT_RST;
            ok_q <= prx_pkg::NP_OK_RST;
            req_q <= 1'b0;
        end else begin
            free_q <= free_q - 5'(np_sof) + 5'(drain); // RULE17 RULE18
            issued_q <= issued_q + 4'(req_d) - 4'(np_sof && NP_REQ_MODE);
            req_q <= req_d;
            if (free_q > prx_pkg::NP_LOW_MARK) begin
                ok_q <= 1'b1; // RULE19
            end else if (np_sof) begin
                ok_q <= 1'b0; // RULE13 RULE16
            end
        end
    end

    // Request mode leaves the throttle high, since the endpoint ignores it
    assign LINK.nonposted_accept_ok = NP_REQ_MODE ? 1'b1 : ok_q; // RULE11
    assign LINK.nonposted_credit_request = req_q; // RULE22
endmodule : prx_user
`default_nettype wire

/* pkg/prx_link_if.sv */
// Receive stream link between the endpoint end and the user end
`timescale 1ns/100ps
`default_nettype none
interface prx_link_if;
    logic tvalid;
    logic tready;
    logic [prx_pkg::QW_W-1:0] tdata;
    logic tlast;
    logic [prx_pkg::STRB_W-1:0] tstrb;
    logic nonposted_accept_ok;
    logic nonposted_credit_request;

    modport dev (
        output tvalid,
        output tdata,
        output tlast,
        output tstrb,
        input tready,
        input nonposted_accept_ok,
        input nonposted_credit_request
    );

    modport usr (
        input tvalid,
        input tdata,
        input tlast,
        input tstrb,
        output tready,
        output nonposted_accept_ok,
        output nonposted_credit_request
    );
endinterface : prx_link_if
`default_nettype wire

/* pkg/prx_pkg.sv */
// Shared constants, types and decode for the receive packet delivery port
package prx_pkg;
    localparam int QW_W = 64;
    localparam int STRB_W = 8;
    localparam logic [7:0] STRB_FULL = 8'hFF;
    localparam logic [7:0] STRB_LOW = 8'h0F;
    localparam int FIFO_DEPTH = 32;
    localparam int PKT_CNT_W = 6;
    localparam int CREDIT_W = 4;
    localparam logic [3:0] NP_CREDIT_MAX = 4'hC;
    localparam logic [4:0] NP_LOW_MARK = 5'h03;
    localparam logic [4:0] NP_SLOTS_DEF = 5'h08;
    localparam logic [4:0] NP_FREE_RST = NP_SLOTS_DEF;
    localparam logic NP_OK_RST = 1'b1;
    localparam logic [PKT_CNT_W-1:0] PKT_CNT_RST = 6'h00;
    localparam logic [CREDIT_W-1:0] CREDIT_RST = 4'h0;
    localparam int DW0_FMT_HI = 31;
    localparam int DW0_FMT_DATA = 30;
    localparam int DW0_TYPE_HI = 28;
    localparam int DW0_TYPE_LO = 24;

    typedef enum logic {
        SRC_PC = 1'b0,
        SRC_NP = 1'b1
    } prx_src_t;

    typedef struct packed {
        logic [PKT_CNT_W-1:0] tag;
        logic half;
        logic last;
        logic [QW_W-1:0] data;
    } prx_beat_t;

    // Reads, locked reads, I/O and configuration requests need a completion
    function automatic logic prx_is_np(input logic [31:0] dw0);
        logic [4:0] typ;
        logic with_data;
        typ = dw0[DW0_TYPE_HI:DW0_TYPE_LO];
        with_data = dw0[DW0_FMT_DATA];
        prx_is_np = ((typ == 5'h00 || typ == 5'h01) && !with_data)
                    || typ == 5'h02 || typ == 5'h04 || typ == 5'h05;
    endfunction : prx_is_np
endpackage : prx_pkg

/* testbench/prx_chk_sva.sv */
// Concurrent checks on the receive stream link between the two ends
`timescale 1ns/100ps
`default_nettype none
module prx_chk #(
    parameter bit NP_REQ_MODE = 1'b0
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Link signals
    input wire logic tvalid,
    input wire logic tready,
    input wire logic [prx_pkg::QW_W-1:0] tdata,
    input wire logic tlast,
    input wire logic [prx_pkg::STRB_W-1:0] tstrb,
    input wire logic nonposted_accept_ok,
    input wire logic nonposted_credit_request
);
    logic sop_q;
    logic [3:0] np_late_q;
    wire logic take = tvalid && tready;
    wire logic [4:0] typ = tdata[28:24];
    wire logic np_kind = ((typ == 5'h00 || typ == 5'h01) && !tdata[30]) || typ == 5'h02
                         || typ == 5'h04 || typ == 5'h05;
    wire logic np_first = take && sop_q && np_kind;

    // Non-posted starts since ok went low; saturates so it never wraps
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            sop_q <= 1'b1;
            np_late_q <= 4'h0;
        end else begin
            if (take) sop_q <= tlast;
            if (nonposted_accept_ok) np_late_q <= 4'h0;
            else if (np_first && np_late_q != 4'hF) np_late_q <= np_late_q + 4'h1;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    sequence s_stall;
        tvalid && !tready;
    endsequence
    sequence s_held;
        tvalid && $stable(tdata) && $stable(tlast) && $stable(tstrb);
    endsequence

    property p_hold; s_stall |=> s_held; endproperty
    a_hold: assert property (p_hold) else $error("Beat changed while stalled");
    property p_no_gap; tvalid && !tlast |=> tvalid; endproperty
    a_no_gap: assert property (p_no_gap) else $error("Valid dropped mid packet");
    property p_strb_last;
        tvalid && tlast |-> tstrb == prx_pkg::STRB_FULL || tstrb == prx_pkg::STRB_LOW;
    endproperty
    a_strb_last: assert property (p_strb_last) else $error("Bad last strobe");
    property p_strb_mid; tvalid && !tlast |-> tstrb == prx_pkg::STRB_FULL; endproperty
    a_strb_mid: assert property (p_strb_mid) else $error("Partial strobe mid packet");
    property p_np_limit; np_late_q <= 4'h2; endproperty
    a_np_limit: assert property (p_np_limit) else $error("Too many late requests");
    property p_mode;
        NP_REQ_MODE ? nonposted_accept_ok : !nonposted_credit_request;
    endproperty
    a_mode: assert property (p_mode) else $error("Unused flow input moved");
    property p_rst;
        disable iff (1'b0) SRST |=> !tvalid && !tlast && tstrb == prx_pkg::STRB_FULL;
    endproperty
    a_rst: assert property (p_rst) else $error("Stream not idle after reset");
    property p_rst_flow;
        disable iff (1'b0) SRST |=> nonposted_accept_ok && !nonposted_credit_request;
    endproperty
    a_rst_flow: assert property (p_rst_flow) else $error("Flow inputs wrong in reset");
endmodule : prx_chk
`default_nettype wire

/* testbench/tb.sv */
// Testbench joining both ends of the receive stream link
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic CLK_SYS = 1'b0;
    logic SRST = 1'b1;
    logic IN_VALID = 1'b0;
    logic IN_READY;
    logic [prx_pkg::QW_W-1:0] IN_DATA = '0;
    logic IN_LAST = 1'b0;
    logic [prx_pkg::STRB_W-1:0] IN_STRB = prx_pkg::STRB_FULL;
    logic OUT_VALID;
    logic OUT_READY = 1'b1;
    logic [prx_pkg::QW_W-1:0] OUT_DATA;
    logic OUT_LAST;
    logic [prx_pkg::STRB_W-1:0] OUT_STRB;
    logic OUT_NP;
    logic NP_DRAIN = 1'b0;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int np_cnt = 0;
    int np_at_pc = 0;
    logic sop_q = 1'b1;
    logic [72:0] mb;
    logic [72:0] exp_np[$];
    logic [72:0] exp_pc[$];

    prx_link_if lk ();
    prx_dev #(.NP_REQ_MODE(1'b0)) prx_dev_i (.CLK_SYS(CLK_SYS), .SRST(SRST),
        .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_DATA(IN_DATA), .IN_LAST(IN_LAST),
        .IN_STRB(IN_STRB), .LINK(lk.dev));
    prx_user #(.NP_REQ_MODE(1'b0)) prx_user_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .LINK(lk.usr),
        .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA),
        .OUT_LAST(OUT_LAST), .OUT_STRB(OUT_STRB), .OUT_NP(OUT_NP), .NP_DRAIN(NP_DRAIN));
    prx_chk #(.NP_REQ_MODE(1'b0)) prx_chk_i (.CLK_SYS(CLK_SYS), .SRST(SRST),
        .tvalid(lk.tvalid), .tready(lk.tready), .tdata(lk.tdata), .tlast(lk.tlast),
        .tstrb(lk.tstrb), .nonposted_accept_ok(lk.nonposted_accept_ok),
        .nonposted_credit_request(lk.nonposted_credit_request));

    always #2.5 CLK_SYS = ~CLK_SYS;

    task automatic end_sim;
        $display("Compares %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [72:0] seen, input logic [72:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Beat image {strobe, last, data}; beat index keeps beats apart
    function automatic logic [72:0] beat(input logic [31:0] dw0, input int i, input int n,
                                         input bit half);
        logic lst;
        lst = (i == n - 1);
        beat = {(lst && half) ? prx_pkg::STRB_LOW : prx_pkg::STRB_FULL, lst, 24'h5A5A5A,
                i[7:0], dw0};
    endfunction : beat

    // Valid stays up so packets go back to back; idle drops it
    task automatic send(input logic [31:0] dw0, input int n, input bit half, input bit np);
        logic [72:0] b;
        for (int i = 0; i < n; i++) begin
            b = beat(dw0, i, n, half);
            if (np) exp_np.push_back(b);
            else exp_pc.push_back(b);
            IN_VALID <= 1'b1;
            {IN_STRB, IN_LAST, IN_DATA} <= b;
            @(posedge CLK_SYS);
            while (IN_READY !== 1'b1) @(posedge CLK_SYS);
        end
    endtask : send

    task automatic idle(input int k);
        IN_VALID <= 1'b0;
        repeat (k) @(posedge CLK_SYS);
    endtask : idle

    task automatic drain(input int k);
        repeat (k) begin
            NP_DRAIN <= 1'b1;
            @(posedge CLK_SYS);
            NP_DRAIN <= 1'b0;
            @(posedge CLK_SYS);
        end
    endtask : drain

    task automatic wait_drain;
        for (int k = 0; k < 500 && exp_np.size() + exp_pc.size() > 0; k++) @(posedge CLK_SYS);
        chk(73'(exp_np.size() + exp_pc.size()), 73'(0));
    endtask : wait_drain

    task automatic t_basic;
        send(32'h4000_0001, 3, 1'b0, 1'b0);
        send(32'h0000_0002, 2, 1'b1, 1'b1);
        send(32'h4A00_0003, 1, 1'b1, 1'b0);
        idle(1);
        wait_drain();
    endtask : t_basic

    // Stalled user end fills the queue until ingress is refused
    task automatic t_fill;
        logic [72:0] b;
        int n;
        n = 0;
        OUT_READY <= 1'b0;
        b = beat(32'h4000_0100, 0, 1, 1'b0);
        IN_VALID <= 1'b1;
        {IN_STRB, IN_LAST, IN_DATA} <= b;
        for (int k = 0; k < 60 && n < 40; k++) begin
            @(posedge CLK_SYS);
            if (IN_READY === 1'b1) begin
                exp_pc.push_back(b);
                n++;
                b[7:0] = 8'(n);
                {IN_STRB, IN_LAST, IN_DATA} <= b;
            end
        end
        IN_VALID <= 1'b0;
        chk(73'(IN_READY), 73'(0));
        chk(73'(n >= prx_pkg::FIFO_DEPTH), 73'(1));
        chk(73'(lk.tvalid), 73'(1));
        OUT_READY <= 1'b1;
        wait_drain();
    endtask : t_fill

    task automatic t_types;
        logic [31:0] np_dw[5];
        np_dw = '{32'h0000_0010, 32'h0100_0011, 32'h0200_0012, 32'h0400_0013, 32'h0500_0014};
        foreach (np_dw[i]) begin
            send(np_dw[i], 2, 1'b1, 1'b1);
            send(32'h4A00_0040, 2, 1'b0, 1'b0);
        end
        idle(10);
        drain(12);
        wait_drain();
    endtask : t_types

    task automatic t_throttle;
        int base;
        base = np_cnt;
        for (int i = 0; i < 10; i++) send(32'h0000_0020 + i, 2, 1'b1, 1'b1);
        send(32'h4000_0030, 2, 1'b0, 1'b0);
        idle(80);
        chk(73'(np_cnt - base < 10), 73'(1));
        chk(73'(np_at_pc - base < 10), 73'(1));
        drain(20);
        send(32'h4000_0031, 1, 1'b0, 1'b0);
        idle(1);
        wait_drain();
        chk(73'(np_at_pc - base), 73'(10));
    endtask : t_throttle

    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles >= 5000) begin
            mismatches++;
            end_sim();
        end
        if (!SRST && OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
            mb = {OUT_STRB, OUT_LAST, OUT_DATA};
            if (OUT_NP === 1'b1 && exp_np.size() > 0) chk(mb, exp_np.pop_front());
            else if (OUT_NP === 1'b0 && exp_pc.size() > 0) chk(mb, exp_pc.pop_front());
            else chk(mb, ~mb);
            if (sop_q && OUT_NP) np_cnt++;
            if (sop_q && !OUT_NP) np_at_pc = np_cnt;
            sop_q = OUT_LAST;
        end
    end

    initial begin
        repeat (8) @(posedge CLK_SYS);
        SRST <= 1'b0;
        @(posedge CLK_SYS);
        chk(73'({lk.tvalid, lk.nonposted_accept_ok, lk.nonposted_credit_request, IN_READY}),
            73'(4'b0101));
        t_basic();
        t_fill();
        t_types();
        t_throttle();
        end_sim();
    end
endmodule : tb
`default_nettype wire
